/* rtl/mic_intc.sv */
// How it works
// - requests latched before a phase-two pulse are dispatched on that pulse
// - fixed priority: bus, pin, timer0, serial a, serial b, timer1
// - global enable cleared blocks all dispatch
// - pin falling edge sets pin flag while the pin is an input; needs global and pin enable
// - enabled pin request with stack room calls vector 08h
// - dispatch clears the served flag and the global enable
// - pull-high option on the shared pin stays in effect
// - timer overflow sets its flag; needs global and timer enable
// - timer0 goes to 0ch, timer1 to 018h
// - serial byte done sets its flag; needs global and own enable
// - serial a goes to 10h, serial b to 14h
// - bus flag set by endpoint access, suspend, resume or bus reset
// - enabled bus request with stack room calls 04h, clears flag and global
// - endpoint access sets its access bit; software clears it
// - suspend sets bus control bit 0, resume sets bit 3
// - set flags stay set until served or cleared by software
// - any source event raises the wake request
// - only the program counter is pushed on entry
// - no dispatch while the stack is full; request stays pending
// - software may set global enable inside a routine to nest
`timescale 1ns/100ps
`default_nettype none
`include "mic_regs.svh"

module mic_intc (
  // clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_b,
  // core sequencer
  input  wire logic                     i_phase_two_pulse,
  input  wire logic                     i_stack_full,
  input  wire logic [11:0]              i_pc,
  // sources
  input  wire logic                     i_port_a_pin_six,
  input  wire logic                     i_port_a_pin6_direction,
  input  wire logic                     i_pull_high_option,
  input  wire mic_pkg::mic_events_t     i_events,
  // software control
  input  wire mic_pkg::mic_sw_t         i_sw,
  // dispatch
  output logic                          o_dispatch,
  output mic_pkg::mic_vec_t             o_vector,
  output logic                          o_push,
  output logic [11:0]                   o_push_pc,
  output logic                          o_wake,
  // status
  output logic                          o_global_irq_enable,
  output mic_pkg::mic_src_t             o_irq_flags,
  output mic_pkg::mic_src_t             o_irq_enables,
  output logic [3:0]                    o_endpoint_access_bits,
  output logic [7:0]                    o_bus_control_register,
  output logic                          o_pin_pull_high
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic                 global_irq_enable;
    mic_pkg::mic_src_t    flags;
    mic_pkg::mic_src_t    enables;
    logic [3:0]           ep_bits;
    logic [7:0]           busctl;
    logic                 dispatch;
    mic_pkg::mic_vec_t    vector;
    logic                 push;
    logic [11:0]          push_pc;
    logic                 wake;
    logic                 pull_high;
  } mic_state_t;

  mic_state_t state_q;
  mic_state_t state_d;

  logic pin_fall;

  mic_edge_detect u_pin_edge (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_level (i_port_a_pin_six),
    .o_fall  (pin_fall)
  );

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic mic_pkg::mic_vec_t vec_of(input int idx);
    unique case (idx)
      `MIC_SRC_BUS:      vec_of = `MIC_VEC_BUS;
      `MIC_SRC_PIN:      vec_of = `MIC_VEC_PIN;
      `MIC_SRC_TIMER0:   vec_of = `MIC_VEC_TIMER0;
      `MIC_SRC_SERIAL_A: vec_of = `MIC_VEC_SERIAL_A;
      `MIC_SRC_SERIAL_B: vec_of = `MIC_VEC_SERIAL_B;
      default:           vec_of = `MIC_VEC_TIMER1;
    endcase
  endfunction

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  mic_pkg::mic_src_t raise;
  mic_pkg::mic_src_t ready;
  logic              bus_evt;
  logic              found;
  int                win;

  always_comb begin
    state_d          = state_q;
    state_d.dispatch = 1'b0;
    state_d.push     = 1'b0;
    found            = 1'b0;
    win              = 0;

    bus_evt = (|i_events.ep_access) | i_events.bus_suspend
            | i_events.bus_resume | i_events.bus_reset;
    raise = '0;
    raise[`MIC_SRC_BUS]      = bus_evt;
    // pin counts only while configured as input
    raise[`MIC_SRC_PIN]      = pin_fall & i_port_a_pin6_direction;
    raise[`MIC_SRC_TIMER0]   = i_events.timer0_ovf;
    raise[`MIC_SRC_TIMER1]   = i_events.timer1_ovf;
    raise[`MIC_SRC_SERIAL_A] = i_events.serial_a_done;
    raise[`MIC_SRC_SERIAL_B] = i_events.serial_b_done;

    state_d.enables   = i_sw.enable;
    state_d.pull_high = i_pull_high_option;
    state_d.wake      = |raise;

    // endpoint and bus control bits: set wins over clear
    state_d.ep_bits = (state_q.ep_bits & ~i_sw.ep_clr) | i_events.ep_access;
    if (i_sw.busctl_clr_suspend) begin
      state_d.busctl[`MIC_BUSCTL_SUSPEND] = 1'b0;
    end
    if (i_sw.busctl_clr_resume) begin
      state_d.busctl[`MIC_BUSCTL_RESUME] = 1'b0;
    end
    if (i_events.bus_suspend) begin
      state_d.busctl[`MIC_BUSCTL_SUSPEND] = 1'b1;
    end
    if (i_events.bus_resume) begin
      state_d.busctl[`MIC_BUSCTL_RESUME] = 1'b1;
    end

    // global enable writes
    if (i_sw.clr_global) begin
      state_d.global_irq_enable = 1'b0;
    end
    if (i_sw.set_global) begin
      state_d.global_irq_enable = 1'b1;
    end

    // flags are sticky regardless of enables
    state_d.flags = (state_q.flags & ~i_sw.flag_clr) | i_sw.flag_set;

    // arbitration on phase-two pulse
    ready = state_q.flags & state_q.enables;
    if (i_phase_two_pulse && state_q.global_irq_enable
        && !i_stack_full) begin
      for (int i = `MIC_NUM_SRC - 1; i >= 0; i--) begin
        if (ready[i]) begin
          found = 1'b1;
          win   = i;
        end
      end
      if (found) begin
        state_d.dispatch          = 1'b1;
        state_d.vector            = vec_of(win);
        state_d.push              = 1'b1;
        state_d.push_pc           = i_pc;
        state_d.flags[win]        = 1'b0;
        state_d.global_irq_enable = 1'b0;
      end
    end

    // new events win over any clear
    state_d.flags = state_d.flags | raise;
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign o_dispatch             = state_q.dispatch;
  assign o_vector               = state_q.vector;
  assign o_push                 = state_q.push;
  assign o_push_pc              = state_q.push_pc;
  assign o_wake                 = state_q.wake;
  assign o_global_irq_enable    = state_q.global_irq_enable;
  assign o_irq_flags            = state_q.flags;
  assign o_irq_enables          = state_q.enables;
  assign o_endpoint_access_bits = state_q.ep_bits;
  assign o_bus_control_register = state_q.busctl;
  assign o_pin_pull_high        = state_q.pull_high;

endmodule

`default_nettype wire

/* rtl/mic_regs.svh */
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// source indices, highest priority first
`define MIC_SRC_BUS        0
`define MIC_SRC_PIN        1
`define MIC_SRC_TIMER0     2
`define MIC_SRC_SERIAL_A   3
`define MIC_SRC_SERIAL_B   4
`define MIC_SRC_TIMER1     5
`define MIC_NUM_SRC        6

// dispatch vectors
`define MIC_VEC_BUS        12'h004
`define MIC_VEC_PIN        12'h008
`define MIC_VEC_TIMER0     12'h00C
`define MIC_VEC_SERIAL_A   12'h010
`define MIC_VEC_SERIAL_B   12'h014
`define MIC_VEC_TIMER1     12'h018

// bus control register bit positions
`define MIC_BUSCTL_SUSPEND 0
`define MIC_BUSCTL_RESUME  3
`define MIC_BUSCTL_WIDTH   8

// endpoint count
`define MIC_NUM_EP         4

`endif

/* rtl/mic_pkg.sv */
package mic_pkg;

  typedef logic [11:0] mic_vec_t;
  typedef logic [5:0]  mic_src_t;

  // one event strobe per timer and serial source plus the bus detail events
  typedef struct packed {
    logic       timer0_ovf;
    logic       timer1_ovf;
    logic       serial_a_done;
    logic       serial_b_done;
    logic       bus_suspend;
    logic       bus_resume;
    logic       bus_reset;
    logic [3:0] ep_access;
  } mic_events_t;

  // software writes of the control bits
  typedef struct packed {
    logic       set_global;
    logic       clr_global;
    mic_src_t   enable;
    mic_src_t   flag_clr;
    mic_src_t   flag_set;
    logic [3:0] ep_clr;
    logic       busctl_clr_suspend;
    logic       busctl_clr_resume;
  } mic_sw_t;

endpackage

/* rtl/mic_edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none

// falling-edge detector on a synchronous pin
module mic_edge_detect (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  // pin
  input  wire logic i_level,
  output logic      o_fall
);

  typedef struct packed {
    logic prev;
  } mic_edge_state_t;

  mic_edge_state_t state_q;
  mic_edge_state_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.prev = i_level;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= '{prev: 1'b1};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_fall = state_q.prev & ~i_level;

endmodule

`default_nettype wire

/* test/mic_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------
// core sequencer: phase pulse every 4th cycle, running pc
// ----------
module mic_core_model (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // dispatch side
  input  wire logic        i_push,
  output logic             o_phase_two_pulse,
  output logic [11:0]      o_pc
);
  logic [1:0] phase_q;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_q           <= 2'h0;
      o_phase_two_pulse <= 1'b0;
      o_pc              <= 12'h020;
    end else begin
      phase_q           <= phase_q + 2'h1;
      o_phase_two_pulse <= (phase_q == 2'h3);
      o_pc              <= i_push ? 12'h100 : o_pc + 12'h001;
    end
  end
endmodule
`default_nettype wire

/* test/mic_intc_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module mic_intc_monitor (
  // inputs
  input wire logic                 i_clock,
  input wire logic                 i_rst_b,
  input wire logic                 i_phase_two_pulse,
  input wire logic                 i_stack_full,
  input wire logic [11:0]          i_pc,
  input wire logic                 i_port_a_pin_six,
  input wire logic                 i_port_a_pin6_direction,
  input wire logic                 i_pull_high_option,
  input wire mic_pkg::mic_events_t i_events,
  // outputs
  input wire logic                 o_dispatch,
  input wire mic_pkg::mic_vec_t    o_vector,
  input wire logic                 o_push,
  input wire logic [11:0]          o_push_pc,
  input wire logic                 o_wake,
  input wire logic                 o_global_irq_enable,
  input wire mic_pkg::mic_src_t    o_irq_flags,
  input wire mic_pkg::mic_src_t    o_irq_enables,
  input wire logic [7:0]           o_bus_control_register,
  input wire logic                 o_pin_pull_high
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  function automatic mic_pkg::mic_vec_t top_vec(input mic_pkg::mic_src_t m);
    top_vec = 12'h000;
    for (int i = 5; i >= 0; i--) begin
      if (m[i]) top_vec = 12'h004 + 12'(4 * i);
    end
  endfunction
  chk_dispatch_cause: assert property (o_dispatch |-> $past(i_phase_two_pulse && o_global_irq_enable && |(o_irq_flags & o_irq_enables))) else $error("dispatch without cause");
  chk_stack_block: assert property (i_stack_full |=> !o_dispatch) else $error("dispatch with stack full");
  chk_global_block: assert property (!o_global_irq_enable |=> !o_dispatch) else $error("dispatch with global off");
  chk_entry_clears: assert property (o_dispatch && !$past(|i_events) |-> !o_global_irq_enable && (o_irq_flags & ~$past(o_irq_flags)) == 6'h00) else $error("entry left global set");
  chk_push_pc: assert property (o_dispatch |-> o_push && o_push_pc == $past(i_pc)) else $error("pushed pc wrong");
  chk_vector_prio: assert property (o_dispatch |-> o_vector == top_vec($past(o_irq_flags & o_irq_enables))) else $error("vector wrong");
  chk_timer_flag: assert property (i_events.timer0_ovf && !i_phase_two_pulse |=> o_irq_flags[2]) else $error("timer flag not set");
  chk_pin_fall: assert property ($fell(i_port_a_pin_six) && i_port_a_pin6_direction && !i_phase_two_pulse |=> o_irq_flags[1]) else $error("pin flag not set");
  chk_suspend_bit: assert property (i_events.bus_suspend && !i_phase_two_pulse |=> o_bus_control_register[0] && o_irq_flags[0]) else $error("suspend not seen");
  chk_wake_any: assert property ((|i_events) |=> o_wake) else $error("no wake");
  chk_pull_copy: assert property (##1 o_pin_pull_high == $past(i_pull_high_option)) else $error("pull option lost");
  cov_dispatch: cover property (o_dispatch);
  cov_stack_wait: cover property (i_stack_full && o_global_irq_enable ##1 !i_stack_full);
  cov_pin_fall: cover property ($fell(i_port_a_pin_six) && i_port_a_pin6_direction);
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                 i_clock, i_rst_b, sfull, pin, pdir, pull, pulse, disp, push, wake, glob, pullo;
  logic [11:0]          pc, ppc;
  logic [3:0]           epb;
  logic [7:0]           bctl;
  mic_pkg::mic_vec_t    vec;
  mic_pkg::mic_src_t    flags, ens;
  mic_pkg::mic_events_t ev;
  mic_pkg::mic_sw_t     sw;
  int                   failures, n_tests, nd;
  mic_core_model core (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_push(push),
    .o_phase_two_pulse(pulse), .o_pc(pc));
  mic_intc dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_phase_two_pulse(pulse),
    .i_stack_full(sfull), .i_pc(pc), .i_port_a_pin_six(pin), .i_port_a_pin6_direction(pdir),
    .i_pull_high_option(pull), .i_events(ev), .i_sw(sw), .o_dispatch(disp), .o_vector(vec),
    .o_push(push), .o_push_pc(ppc), .o_wake(wake), .o_global_irq_enable(glob),
    .o_irq_flags(flags), .o_irq_enables(ens), .o_endpoint_access_bits(epb),
    .o_bus_control_register(bctl), .o_pin_pull_high(pullo));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (disp === 1'b1) nd++;
  task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic sw_pulse(input mic_pkg::mic_src_t fs, input mic_pkg::mic_src_t fc, input logic sg);
    @(posedge i_clock) sw <= {sg, 1'b0, sw.enable, fc, fs, 6'h00};
    @(posedge i_clock) sw <= {2'h0, sw.enable, 18'h0_0000};
  endtask
  task automatic ev_pulse(input mic_pkg::mic_events_t e);
    @(posedge i_clock) ev <= e;
    @(posedge i_clock) ev <= '0;
  endtask
  task automatic wait_disp(input logic [11:0] v);
    int k;
    logic [11:0] prev;
    k = 0;
    prev = pc;
    while (disp !== 1'b1 && k < 40) begin
      prev = pc;
      @(negedge i_clock);
      k++;
    end
    cmp("vector", v, vec);
    cmp("push_pc", prev, ppc);
    cmp("push", 12'h001, {11'h000, push});
    cmp("global", 12'h000, {11'h000, glob});
    tick(1);
  endtask
  task automatic t_timer();
    @(posedge i_clock) sw.enable <= 6'h04;
    ev_pulse('{timer0_ovf: 1'b1, default: '0});
    tick(1);
    cmp("t0 flag", 12'h004, {6'h00, flags});
    cmp("enables", 12'h004, {6'h00, ens});
    sw_pulse(6'h00, 6'h00, 1'b1);
    wait_disp(12'h00C);
    cmp("t0 clear", 12'h000, {6'h00, flags});
  endtask
  task automatic t_mask();
    int n0;
    n0 = nd;
    @(posedge i_clock) sw.enable <= 6'h00;
    sw_pulse(6'h20, 6'h00, 1'b1);
    tick(16);
    cmp("masked", 12'(n0), 12'(nd));
    @(posedge i_clock) sfull <= 1'b1;
    @(posedge i_clock) sw.enable <= 6'h20;
    tick(16);
    cmp("stack full", 12'(n0), 12'(nd));
    cmp("held", 12'h020, {6'h00, flags});
    @(posedge i_clock) sfull <= 1'b0;
    wait_disp(12'h018);
    sw_pulse(6'h20, 6'h00, 1'b0);
    tick(16);
    cmp("global off", 12'(n0 + 1), 12'(nd));
    sw_pulse(6'h00, 6'h20, 1'b0);
    tick(1);
    cmp("sw clear", 12'h000, {6'h00, flags});
  endtask
  task automatic t_prio();
    @(posedge i_clock) sw.enable <= 6'h3F;
    sw_pulse(6'h3F, 6'h00, 1'b0);
    for (int k = 0; k < 6; k++) begin
      sw_pulse(6'h00, 6'h00, 1'b1);
      wait_disp(12'h004 + 12'(4 * k));
    end
  endtask
  task automatic t_pin();
    @(posedge i_clock) pdir <= 1'b1;
    @(posedge i_clock) pin <= 1'b0;
    tick(2);
    cmp("pin flag", 12'h002, {6'h00, flags});
    sw_pulse(6'h00, 6'h02, 1'b0);
    @(posedge i_clock) pin <= 1'b1;
    pdir <= 1'b0;
    pull <= 1'b1;
    @(posedge i_clock) pin <= 1'b0;
    tick(2);
    cmp("pin output", 12'h000, {6'h00, flags});
    cmp("pull", 12'h001, {11'h000, pullo});
  endtask
  task automatic t_bus();
    ev_pulse('{bus_suspend: 1'b1, ep_access: 4'h4, default: '0});
    @(negedge i_clock);
    cmp("wake", 12'h001, {11'h000, wake});
    cmp("ep bits", 12'h004, {8'h00, epb});
    cmp("bus flag", 12'h001, {6'h00, flags});
    ev_pulse('{bus_resume: 1'b1, default: '0});
    tick(1);
    cmp("bus ctl", 12'h009, {4'h0, bctl});
    ev_pulse('{bus_reset: 1'b1, serial_a_done: 1'b1, serial_b_done: 1'b1, timer1_ovf: 1'b1,
      default: '0});
    tick(1);
    cmp("event flags", 12'h039, {6'h00, flags});
    @(posedge i_clock) sw.ep_clr <= 4'h4;
    @(posedge i_clock) sw.ep_clr <= 4'h0;
    tick(1);
    cmp("ep clear", 12'h000, {8'h00, epb});
  endtask
  task automatic summarize();
    $display("failures %0d comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    {i_rst_b, sfull, pdir, pull} = 4'h0;
    pin = 1'b1;
    ev = '0;
    sw = '0;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    tick(1);
    cmp("reset", 12'h000, {5'h00, glob, flags});
    t_timer();
    t_mask();
    t_prio();
    t_pin();
    t_bus();
    summarize();
  end
endmodule
bind mic_intc mic_intc_monitor mon (.*);
`default_nettype wire
